//--- verilog/overvoltage_stage_timing.sv
// overvoltage stage: pick-up, blocking, operate and release timing, ahb-lite registers
// assumes a single 100 MHz clock and measured levels synchronous to it
`timescale 1ns/10ps
`include "ov_stage_map.svh"

module overvoltage_stage_timing
    import ov_stage_pkg::*;
#(
    parameter int TICK_CYCLES = (`EVAL_PERIOD_US * 1000) / `CLK_PERIOD_NS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire levels_t     measured_level,
    input  wire logic        overvoltage_block,
    output logic             start_out,
    output logic             trip_out,
    output logic             blocked_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    cfg_t         cfg_q;
    stage_state_t state_q;
    logic [TW-1:0] tick_cnt_q;
    logic          tick_q;
    logic          blk_q;
    logic [2:0]    phase_pu_q;
    logic [19:0]   op_cnt_q;
    logic [19:0]   rel_cnt_q;
    logic [19:0]   target_q;
    logic [19:0]   idmt_ticks_q;
    logic [15:0]   ratio_q [4];
    logic [7:0]    wr_addr_q;
    logic          wr_pend_q;

    // bus address phase
    function automatic logic [7:0] word_offset(input logic [31:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_offset

    logic addr_ok;
    assign addr_ok = hsel & htrans[1] & hready;

    // evaluation tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TW'(TICK_CYCLES - 1));
            if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + TW'(1);
            end
        end
    end

    // block sampled once per tick, on the last count before it, mode blocked forces it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_q <= 1'b0;
        end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
            blk_q <= overvoltage_block;
        end
    end

    logic mode_blk;
    logic mode_off;
    assign mode_blk = (cfg_q.node_mode == MODE_BLOCKED) | (cfg_q.node_mode == MODE_TEST_BLOCKED);
    assign mode_off = (cfg_q.node_mode == MODE_OFF);

    // per-phase pick-up with 97 percent reset ratio
    logic [15:0] lvl [3];
    assign lvl[0] = measured_level.a;
    assign lvl[1] = measured_level.b;
    assign lvl[2] = measured_level.c;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    phase_pu_q[g] <= 1'b0;
                end else if (lvl[g] > cfg_q.threshold) begin
                    phase_pu_q[g] <= 1'b1;
                end else if ({7'h00, lvl[g]} * 23'd100 < {7'h00, cfg_q.threshold} * 23'd97) begin
                    phase_pu_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // voltages needed: 0 one, 1 two, 2 or 3 all three
    logic [1:0] pu_count;
    logic       pickup;
    assign pu_count = 2'(phase_pu_q[0]) + 2'(phase_pu_q[1]) + 2'(phase_pu_q[2]);
    always_comb begin
        unique case (cfg_q.voltages_needed)
            2'h0:    pickup = (pu_count >= 2'd1);
            2'h1:    pickup = (pu_count >= 2'd2);
            default: pickup = (pu_count == 2'd3);
        endcase
    end

    // sequential divider: three phase ratios, overall ratio, inverse time
    logic [31:0] div_n_q;
    logic [31:0] div_d_q;
    logic [31:0] div_q_q;
    logic [31:0] div_r_q;
    logic [5:0]  div_bit_q;
    logic [2:0]  div_op_q;
    logic        div_busy_q;
    logic [32:0] div_trial;
    assign div_trial = {div_r_q, div_n_q[31]} - {1'b0, div_d_q};

    // inverse denominator: ratio^a - 1 by second order series about ratio 1
    logic signed [63:0] x_s;
    logic signed [63:0] a_s;
    logic signed [63:0] den_s;
    logic [31:0]        den;
    always_comb begin
        x_s   = 64'(signed'({1'b0, ratio_q[3]})) - 64'sd100;
        a_s   = 64'(signed'({1'b0, cfg_q.expo}));
        den_s = a_s * x_s + (a_s * (a_s - 64'sd100) * x_s * x_s) / 64'sd2000000;
        if (den_s <= 0) begin
            den = 32'h0;
        end else if (den_s > 64'sh0ffffffff) begin
            den = 32'hffffffff;
        end else begin
            den = den_s[31:0];
        end
    end

    logic [31:0] max_lvl;
    assign max_lvl = {16'h0000, (lvl[0] > lvl[1]) ?
                     ((lvl[0] > lvl[2]) ? lvl[0] : lvl[2]) :
                     ((lvl[1] > lvl[2]) ? lvl[1] : lvl[2])};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_n_q      <= '0;
            div_d_q      <= 32'h1;
            div_q_q      <= '0;
            div_r_q      <= '0;
            div_bit_q    <= '0;
            div_op_q     <= '0;
            div_busy_q   <= 1'b0;
            idmt_ticks_q <= `MAX_OP_TICKS;
            for (int i = 0; i < 4; i++) begin
                ratio_q[i] <= '0;
            end
        end else if (!div_busy_q) begin
            if (tick_q || div_op_q != 3'd0) begin
                div_busy_q <= 1'b1;
                div_bit_q  <= 6'd32;
                div_r_q    <= '0;
                div_d_q    <= (cfg_q.threshold == 16'h0) ? 32'h1 : {16'h0000, cfg_q.threshold};
                unique case (div_op_q)
                    3'd0:    div_n_q <= {16'h0000, lvl[0]} * 32'd100;
                    3'd1:    div_n_q <= {16'h0000, lvl[1]} * 32'd100;
                    3'd2:    div_n_q <= {16'h0000, lvl[2]} * 32'd100;
                    3'd3:    div_n_q <= max_lvl * 32'd100;
                    default: begin
                        div_n_q <= {16'h0000, cfg_q.dial} * 32'd20000;
                        div_d_q <= (den == 32'h0) ? 32'h1 : den;
                    end
                endcase
            end
        end else if (div_bit_q != 6'd0) begin
            div_bit_q <= div_bit_q - 6'd1;
            div_n_q   <= {div_n_q[30:0], 1'b0};
            if (!div_trial[32]) begin
                div_r_q <= div_trial[31:0];
                div_q_q <= {div_q_q[30:0], 1'b1};
            end else begin
                div_r_q <= {div_r_q[30:0], div_n_q[31]};
                div_q_q <= {div_q_q[30:0], 1'b0};
            end
        end else begin
            div_busy_q <= 1'b0;
            if (div_op_q == 3'd4) begin
                div_op_q <= 3'd0;
                // recomputed once per tick from the present level
                if (den == 32'h0 || div_q_q > 32'(`MAX_OP_TICKS)) begin
                    idmt_ticks_q <= `MAX_OP_TICKS;
                end else begin
                    idmt_ticks_q <= div_q_q[19:0];
                end
            end else begin
                ratio_q[div_op_q[1:0]] <= (div_q_q > 32'h0000ffff) ? 16'hffff : div_q_q[15:0];
                div_op_q <= div_op_q + 3'd1;
            end
        end
    end

    // operate target: definite or inverse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_q <= `RST_DT_DELAY;
        end else if (cfg_q.delay_inverse) begin
            target_q <= idmt_ticks_q;
        end else begin
            target_q <= cfg_q.dt_delay;
        end
    end

    logic op_due;
    logic act_blk;
    assign op_due  = (target_q == 20'h0) | (op_cnt_q + 20'h1 >= target_q);
    assign act_blk = blk_q | mode_blk;

    // stage timing state machine, one step per tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= ST_IDLE;
            op_cnt_q  <= '0;
            rel_cnt_q <= '0;
            start_out <= 1'b0;
            trip_out  <= 1'b0;
            blocked_out <= 1'b0;
        end else if (mode_off) begin
            state_q   <= ST_IDLE;
            op_cnt_q  <= '0;
            rel_cnt_q <= '0;
            start_out <= 1'b0;
            trip_out  <= 1'b0;
            blocked_out <= 1'b0;
        end else if (tick_q) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (pickup && act_blk) begin
                        state_q     <= ST_BLOCKED;
                        blocked_out <= 1'b1;
                    end else if (pickup) begin
                        state_q   <= ST_RUN;
                        start_out <= 1'b1;
                        if (target_q == 20'h0) begin
                            trip_out <= 1'b1;
                        end else begin
                            op_cnt_q <= op_cnt_q + 20'h1;
                        end
                    end
                end
                ST_RUN: begin
                    if (trip_out && !pickup) begin
                        state_q   <= ST_IDLE;
                        start_out <= 1'b0;
                        trip_out  <= 1'b0;
                        op_cnt_q  <= '0;
                    end else if (!trip_out && (act_blk || !pickup)) begin
                        state_q   <= ST_RELEASE;
                        rel_cnt_q <= '0;
                        start_out <= cfg_q.delayed_release & ~act_blk;
                        if (act_blk && pickup) begin
                            blocked_out <= 1'b1;
                        end
                        if (!cfg_q.reset_after_release) begin
                            op_cnt_q <= '0;
                        end
                    end else if (!trip_out) begin
                        if (op_due) begin
                            trip_out <= 1'b1;
                        end
                        op_cnt_q <= op_cnt_q + 20'h1;
                    end
                end
                ST_RELEASE: begin
                    blocked_out <= pickup & act_blk;
                    start_out   <= start_out & ~act_blk;
                    if (pickup && !act_blk) begin
                        state_q   <= ST_RUN;
                        start_out <= 1'b1;
                    end else if (rel_cnt_q + 20'h1 >= cfg_q.rel_delay) begin
                        state_q   <= ST_IDLE;
                        start_out <= 1'b0;
                        if (cfg_q.reset_after_release) begin
                            op_cnt_q <= '0;
                        end
                    end else begin
                        rel_cnt_q <= rel_cnt_q + 20'h1;
                        if (cfg_q.continue_in_release && cfg_q.reset_after_release) begin
                            op_cnt_q <= op_cnt_q + 20'h1;
                        end
                    end
                end
                ST_BLOCKED: begin
                    if (!pickup) begin
                        state_q     <= ST_IDLE;
                        blocked_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // remaining time, signed, 5 ms steps
    logic signed [31:0] remain;
    assign remain = (state_q == ST_RUN && !trip_out) ?
                    32'(signed'({1'b0, target_q})) - 32'(signed'({1'b0, op_cnt_q})) : 32'sd0;

    function automatic logic [31:0] read_word(input logic [7:0] ofs);
        unique case (ofs)
            `OFS_CTRL:      read_word = {23'h0, cfg_q.node_mode, cfg_q.voltages_needed,
                                         cfg_q.continue_in_release, cfg_q.reset_after_release,
                                         cfg_q.delayed_release, cfg_q.delay_inverse};
            `OFS_THRESH:    read_word = {16'h0, cfg_q.threshold};
            `OFS_DT_DELAY:  read_word = {12'h0, cfg_q.dt_delay};
            `OFS_DIAL:      read_word = {16'h0, cfg_q.dial};
            `OFS_EXPO:      read_word = {16'h0, cfg_q.expo};
            `OFS_REL_DELAY: read_word = {12'h0, cfg_q.rel_delay};
            `OFS_STATUS:    read_word = {26'h0, cfg_q.node_mode, blocked_out, trip_out,
                                         start_out};
            `OFS_REMAIN:    read_word = remain;
            `OFS_EXPECT:    read_word = {12'h0, target_q};
            `OFS_RATIO_A:   read_word = {16'h0, ratio_q[0]};
            `OFS_RATIO_B:   read_word = {16'h0, ratio_q[1]};
            `OFS_RATIO_C:   read_word = {16'h0, ratio_q[2]};
            `OFS_RATIO_ALL: read_word = {16'h0, ratio_q[3]};
            default:        read_word = 32'h0;
        endcase
    endfunction : read_word

    // bus answer: zero wait, read data latched at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= word_offset(haddr);
            if (addr_ok && !hwrite) begin
                hrdata <= read_word(word_offset(haddr));
            end
        end
    end

    // configuration writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {cfg_q.node_mode, cfg_q.voltages_needed, cfg_q.continue_in_release,
             cfg_q.reset_after_release, cfg_q.delayed_release,
             cfg_q.delay_inverse} <= `RST_CTRL;
            cfg_q.threshold <= `RST_THRESH;
            cfg_q.dt_delay  <= `RST_DT_DELAY;
            cfg_q.dial      <= `RST_DIAL;
            cfg_q.expo      <= `RST_EXPO;
            cfg_q.rel_delay <= `RST_REL_DELAY;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                `OFS_CTRL: begin
                    cfg_q.delay_inverse       <= hwdata[`CTRL_DELAY_TYPE];
                    cfg_q.delayed_release     <= hwdata[`CTRL_DLY_REL];
                    cfg_q.reset_after_release <= hwdata[`CTRL_RST_AFTER];
                    cfg_q.continue_in_release <= hwdata[`CTRL_CONT_REL];
                    cfg_q.voltages_needed     <= hwdata[`CTRL_OPMODE_LO +: 2];
                    cfg_q.node_mode <= (hwdata[`CTRL_NMODE_LO +: 3] > 3'd4) ? MODE_OFF :
                                       node_mode_t'(hwdata[`CTRL_NMODE_LO +: 3]);
                end
                `OFS_THRESH:    cfg_q.threshold <= hwdata[15:0];
                `OFS_DT_DELAY:  cfg_q.dt_delay  <= hwdata[19:0];
                `OFS_DIAL:      cfg_q.dial      <= hwdata[15:0];
                `OFS_EXPO:      cfg_q.expo      <= hwdata[15:0];
                `OFS_REL_DELAY: cfg_q.rel_delay <= hwdata[19:0];
                default: ;
            endcase
        end
    end
endmodule : overvoltage_stage_timing

//--- verilog/ov_stage_map.svh
// constants of the overvoltage stage: register offsets, fields, resets, timing
// assumes inclusion by the stage module and the bench only
`ifndef OV_STAGE_MAP_SVH
`define OV_STAGE_MAP_SVH

// timing
`define CLK_PERIOD_NS     10
`define EVAL_PERIOD_US    5000
`define MAX_OP_TICKS      20'h57e40

// byte offsets on the register bus
`define OFS_CTRL          8'h00
`define OFS_THRESH        8'h04
`define OFS_DT_DELAY      8'h08
`define OFS_DIAL          8'h0c
`define OFS_EXPO          8'h10
`define OFS_REL_DELAY     8'h14
`define OFS_STATUS        8'h18
`define OFS_REMAIN        8'h1c
`define OFS_EXPECT        8'h20
`define OFS_RATIO_A       8'h24
`define OFS_RATIO_B       8'h28
`define OFS_RATIO_C       8'h2c
`define OFS_RATIO_ALL     8'h30

// control register fields
`define CTRL_DELAY_TYPE   0
`define CTRL_DLY_REL      1
`define CTRL_RST_AFTER    2
`define CTRL_CONT_REL     3
`define CTRL_OPMODE_LO    4
`define CTRL_NMODE_LO     6

// reset values
`define RST_CTRL          9'h006
`define RST_THRESH        16'h2904
`define RST_DT_DELAY      20'h00008
`define RST_DIAL          16'h0005
`define RST_EXPO          16'h0064
`define RST_REL_DELAY     20'h0000c

`endif

//--- verilog/ov_stage_pkg.sv
// types of the overvoltage stage
// assumes ov_stage_map.svh for the field constants
package ov_stage_pkg;
    typedef enum logic [2:0] {
        MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
    } node_mode_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RELEASE, ST_BLOCKED} stage_state_t;

    typedef struct packed {
        logic        delay_inverse;
        logic        delayed_release;
        logic        reset_after_release;
        logic        continue_in_release;
        logic [1:0]  voltages_needed;
        node_mode_t  node_mode;
        logic [15:0] threshold;
        logic [19:0] dt_delay;
        logic [15:0] dial;
        logic [15:0] expo;
        logic [19:0] rel_delay;
    } cfg_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } levels_t;
endpackage : ov_stage_pkg

//--- bench/ov_stage_sva.sv
// checker: bus answer and output pacing of the overvoltage stage
// assumes a bind onto overvoltage_stage_timing with its tick parameter
`timescale 1ns/10ps
module ov_stage_sva
    import ov_stage_pkg::*;
#(
    parameter int TICK_CYCLES = 20
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        overvoltage_block,
    input wire logic        start_out,
    input wire logic        trip_out,
    input wire logic        blocked_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] outs_q;
    int         gap_q;
    // cycles since the stage outputs last moved
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            outs_q <= 3'h0;
            gap_q  <= TICK_CYCLES;
        end else begin
            outs_q <= {start_out, trip_out, blocked_out};
            if ({start_out, trip_out, blocked_out} != outs_q) begin
                gap_q <= 1;
            end else if (gap_q < TICK_CYCLES) begin
                gap_q <= gap_q + 1;
            end
        end
    end
    sequence rd_unmapped;
        hsel && htrans[1] && hready && !hwrite && haddr == 32'h40;
    endsequence
    sequence block_seen;
        $past(overvoltage_block, 1) || $past(overvoltage_block, 2) || $past(overvoltage_block, 3);
    endsequence
    ready_always_a: assert property (hreadyout) else $error("wait state inserted");
    resp_okay_a: assert property (!hresp) else $error("error response given");
    unmapped_zero_a: assert property (rd_unmapped |=> hrdata == 32'h0)
        else $error("unmapped word not zero");
    trip_with_start_a: assert property (trip_out |-> start_out)
        else $error("trip without start");
    blocked_alone_a: assert property (blocked_out |-> !start_out && !trip_out)
        else $error("blocked together with start");
    start_unblocked_a: assert property ($rose(start_out) |-> !($past(overvoltage_block, 1) &&
        $past(overvoltage_block, 2) && $past(overvoltage_block, 3)))
        else $error("start raised under block");
    blocked_cause_a: assert property ($rose(blocked_out) |-> block_seen)
        else $error("blocked without block input");
    tick_paced_a: assert property ({start_out, trip_out, blocked_out} != outs_q
        |-> gap_q >= TICK_CYCLES) else $error("outputs moved between ticks");
endmodule : ov_stage_sva

//--- bench/ov_source_model.sv
// source model: measured phase levels and the block line from the matrix
// assumes calls from the bench; changes land just after a rising edge
`timescale 1ns/10ps
module ov_source_model
    import ov_stage_pkg::*;
(
    input  wire logic hclk,
    output levels_t   measured_level,
    output logic      overvoltage_block
);
    initial begin
        measured_level = '0;
        overvoltage_block = 1'b0;
    end
    task automatic drive(input logic [15:0] a, b, c, input logic blk);
        @(posedge hclk);
        measured_level <= {a, b, c};
        overvoltage_block <= blk; // changed on the same edge as the levels
    endtask : drive
endmodule : ov_source_model

//--- bench/tb_overvoltage_stage_timing.sv
// bench: register defaults and stage timing through ahb-lite and the source model
// assumes a shortened tick of 250 cycles
`timescale 1ns/10ps
`include "ov_stage_map.svh"
module tb_overvoltage_stage_timing
    import ov_stage_pkg::*;
;
    localparam int T = 250;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        blk, start_out, trip_out, blocked_out;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    levels_t     lvl;
    int          num_errors = 0;
    int          checks_done = 0;
    int          c;
    time         t0;
    logic [31:0] ra [7] = '{`OFS_CTRL, `OFS_THRESH, `OFS_DT_DELAY, `OFS_DIAL, `OFS_EXPO,
                            `OFS_REL_DELAY, 32'h40};
    logic [31:0] rv [7] = '{32'h006, 32'h2904, 32'h8, 32'h5, 32'h64, 32'hc, 32'h0};
    overvoltage_stage_timing #(.TICK_CYCLES(T)) u_overvoltage_stage_timing (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .measured_level(lvl),
        .overvoltage_block(blk), .start_out(start_out), .trip_out(trip_out),
        .blocked_out(blocked_out));
    ov_source_model u_ov_source_model (.hclk(hclk), .measured_level(lvl), .overvoltage_block(blk));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string name, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            $display("BAD hready expected 1 seen %b", hreadyout);
            num_errors++;
            complete_run();
        end
    endtask : bus_wait
    task automatic xfer(input logic w, input logic [31:0] a, wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        bus_wait();
        r = hrdata;
    endtask : xfer
    task automatic wait_out(input int w, input logic v, input int lim);
        c = 0;
        while ((w == 0 ? start_out : w == 1 ? trip_out : blocked_out) !== v) begin
            @(negedge hclk);
            c++;
            if (c > lim) begin
                $display("BAD output %0d expected %b seen other", w, v);
                num_errors++;
                complete_run();
            end
        end
    endtask : wait_out
    task automatic lv(input logic [15:0] a, b, input logic bk);
        u_ov_source_model.drive(a, b, 16'h0, bk);
    endtask : lv
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, ra[i], '0);
            chk("reset value", rv[i], r);
        end
        lv(16'h2af8, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        t0 = $time;
        wait_out(1, 1'b1, 9 * T);
        chk("definite ticks", 32'd7, 32'(($time - t0) / (10 * T)));
        xfer(1'b0, `OFS_STATUS, '0);
        chk("status tripped", 32'h3, r);
        xfer(1'b0, `OFS_RATIO_A, '0);
        chk("ratio a", 32'h1, {31'h0, r == 32'd104 || r == 32'd105});
        xfer(1'b0, `OFS_RATIO_B, '0);
        chk("ratio b", 32'h0, r);
        lv(16'h0, 16'h0, 1'b0);
        wait_out(0, 1'b0, 2 * T);
        xfer(1'b1, `OFS_CTRL, 32'h004);
        xfer(1'b1, `OFS_DT_DELAY, 32'd40);
        lv(16'h2af8, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        lv(16'h283c, 16'h0, 1'b0);
        xfer(1'b0, `OFS_REMAIN, '0);
        chk("remaining", 32'h1, {31'h0, $signed(r) > 0 && $signed(r) <= 40});
        repeat (4 * T) @(negedge hclk);
        chk("start above reset ratio", 32'h1, {31'h0, start_out});
        lv(16'h2710, 16'h0, 1'b0);
        wait_out(0, 1'b0, 2 * T);
        xfer(1'b1, `OFS_CTRL, 32'h006);
        lv(16'h2af8, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        lv(16'h0, 16'h0, 1'b0);
        t0 = $time;
        wait_out(0, 1'b0, 20 * T);
        r = 32'(($time - t0) / (10 * T));
        chk("release ticks", 32'h1, {31'h0, r >= 11 && r <= 13});
        xfer(1'b1, `OFS_DT_DELAY, 32'h0);
        lv(16'h2af8, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        chk("instant trip", 32'h1, {31'h0, trip_out});
        lv(16'h0, 16'h0, 1'b0);
        wait_out(0, 1'b0, 2 * T);
        // two voltages needed, test mode
        xfer(1'b1, `OFS_CTRL, 32'h096);
        xfer(1'b1, `OFS_DT_DELAY, 32'd40);
        lv(16'h2af8, 16'h0, 1'b0);
        repeat (3 * T) @(negedge hclk);
        chk("one of two", 32'h0, {31'h0, start_out});
        lv(16'h2af8, 16'h2af8, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        xfer(1'b0, `OFS_STATUS, '0);
        chk("status test mode", 32'h11, r);
        xfer(1'b1, `OFS_CTRL, 32'h006);
        lv(16'h0, 16'h0, 1'b0);
        wait_out(0, 1'b0, 20 * T);
        lv(16'h2af8, 16'h0, 1'b1);
        wait_out(2, 1'b1, 3 * T);
        chk("start while blocked", 32'h0, {31'h0, start_out});
        lv(16'h0, 16'h0, 1'b0);
        wait_out(2, 1'b0, 20 * T);
        lv(16'h2af8, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        lv(16'h2af8, 16'h0, 1'b1);
        wait_out(0, 1'b0, 2 * T);
        chk("blocked after start", 32'h1, {31'h0, blocked_out});
        lv(16'h0, 16'h0, 1'b0);
        wait_out(2, 1'b0, 20 * T);
        repeat (14 * T) @(negedge hclk);
        // inverse time, dial 50 ms, exponent 1.00
        xfer(1'b1, `OFS_CTRL, 32'h007);
        lv(16'h2d1e, 16'h0, 1'b0);
        wait_out(0, 1'b1, 3 * T);
        repeat (2 * T) @(negedge hclk);
        xfer(1'b0, `OFS_EXPECT, '0);
        chk("expected at 1.1", 32'h1, {31'h0, r >= 99 && r <= 101});
        lv(16'h3138, 16'h0, 1'b0);
        repeat (2 * T) @(negedge hclk);
        xfer(1'b0, `OFS_EXPECT, '0);
        chk("expected at 1.2", 32'h1, {31'h0, r >= 49 && r <= 51});
        wait_out(1, 1'b1, 60 * T);
        complete_run();
    end
endmodule : tb_overvoltage_stage_timing
bind overvoltage_stage_timing ov_stage_sva #(.TICK_CYCLES(TICK_CYCLES)) u_ov_stage_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .overvoltage_block(overvoltage_block), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out));
